// >>> logic/sis_irq_frame_ctrl.sv
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - masked status register is read-only; writes to it change nothing
// - masked bits 3..0 are raw bits ANDed with enables at bits 7..4
// - masked bit 3 is tx under-run raw AND its enable; resets low
// - masked bit 2 is rx overflow raw AND its enable; resets low
// - masked bit 1 is rx ready raw AND its enable; resets low
// - masked bit 0 is tx complete raw AND its enable; resets low
// - masked bits 5 and 4 read high while those interrupts are active
// - raw bit 5 sets when slave select 0 goes from active to inactive
// - raw bit 4 sets when command-size frames arrive within one select
// - raw bits 3..0 read-only, reset low, layout under-run, overflow, ready, done
// - frame counter enabled: at its limit the transfer pauses
// - frame counter disabled: counter idle, transmit runs until FIFO empty
// - first-frame discard drops the first frame after select goes active
// - status-first-frame sends hardware status as first slave frame
// - command counter restarts on select release outside TI mode and on TI-mode gaps
module sis_irq_frame_ctrl
  import sis_pkg::*;
#(
  parameter int FRAME_BITS = 8,
  parameter int GAP_CYCLES = 16
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // wishbone slave
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [ADR_W-1:0] wb_adr,
  input  wire logic [3:0]       wb_sel,
  input  wire logic [DAT_W-1:0] wb_dat_w,
  output logic      [DAT_W-1:0] wb_dat_r,
  output logic                  wb_ack,
  // serial link pins
  input  wire logic             sclkPin,
  input  wire logic             slaveSelectLine0,
  // datapath status and settings
  input  wire logic             txUnderrunRaw,
  input  wire logic             rxOverflowRaw,
  input  wire logic             rxReadyRaw,
  input  wire logic             txCompleteRaw,
  input  wire logic [CNT_W-1:0] commandFrameCount,
  input  wire logic [CNT_W-1:0] frameCountLimit,
  input  wire logic             slaveMode,
  input  wire logic             tiMode,
  input  wire logic             clrFrameCount,
  // outputs to datapath and system
  output logic                  irqOut,
  output logic                  xferPause,
  output logic                  drainToEmpty,
  output logic                  frameDone,
  output logic                  rxDiscard,
  output logic                  txStatusSel
);

  // ------------------------------------------------------------------
  // constants and state
  // ------------------------------------------------------------------
  localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(GAP_CYCLES - 1);

  sis_state_type    st_ff;
  sis_state_type    nxt_st;

  logic             wbReq;
  logic             wbWr;
  logic [IDX_W-1:0] regIdx;
  logic             sclkAgree;
  logic             sclkRise;
  logic             ssAgree;
  logic             ssChange;
  logic             ssGoAct;
  logic             ssGoIdle;
  logic             ssActive;
  logic             frameEnd;
  logic             cmdHit;
  logic             gapExpired;
  logic             cfgWrite;
  logic [CNT_W-1:0] cmdNext;
  logic [CNT_W-1:0] frmNext;
  logic [RAW_W-1:0] rawClr;
  logic [RAW_W-1:0] curMasked;
  logic [RAW_W-1:0] nxtMasked;
  logic [DAT_W-1:0] rdData;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st    = st_ff;
    regIdx    = wb_adr[ADR_W-1:ADR_LSB];
    wbReq     = wb_cyc & wb_stb & ~st_ff.wbAck;
    wbWr      = wbReq & wb_we & wb_sel[0];
    cfgWrite  = wbWr & (regIdx == IDX_CFG);
    rawClr    = '0;
    rdData    = '0;

    // pin sampling: a change counts once stages two and three agree
    nxt_st.sclkSync = {st_ff.sclkSync[SYNC_N-2:0], sclkPin};
    nxt_st.ssSync   = {st_ff.ssSync[SYNC_N-2:0], slaveSelectLine0};
    sclkAgree = st_ff.sclkSync[1] == st_ff.sclkSync[2];
    ssAgree   = st_ff.ssSync[1] == st_ff.ssSync[2];
    if (sclkAgree) begin
      nxt_st.sclkLvl = st_ff.sclkSync[2];
    end
    if (ssAgree) begin
      nxt_st.ssLvl = st_ff.ssSync[2];
    end
    sclkRise = sclkAgree & st_ff.sclkSync[2] & ~st_ff.sclkLvl;
    ssChange = ssAgree & (st_ff.ssSync[2] != st_ff.ssLvl);
    // select is active low, inverted to active high in TI mode
    ssGoAct  = ssChange & (st_ff.ssSync[2] == tiMode);
    ssGoIdle = ssChange & (st_ff.ssSync[2] != tiMode);
    ssActive = st_ff.ssLvl == tiMode;

    // frame framing: TI frames run on from the sync pulse
    frameEnd = (ssActive | tiMode) & sclkRise & (st_ff.bitCnt == FRAME_LAST);
    if (ssGoAct | (ssGoIdle & ~tiMode)) begin
      nxt_st.bitCnt = '0;
    end else if ((ssActive | tiMode) & sclkRise) begin
      nxt_st.bitCnt = frameEnd ? '0 : st_ff.bitCnt + CNT_ONE;
    end

    if (ssGoAct) begin
      nxt_st.firstFrame = 1'b1;
    end else if (frameEnd | ssGoIdle) begin
      nxt_st.firstFrame = 1'b0;
    end

    // command frame counter
    cmdNext    = st_ff.cmdCnt + CNT_ONE;
    cmdHit     = frameEnd & (commandFrameCount != '0) & (cmdNext == commandFrameCount);
    gapExpired = tiMode & (st_ff.gapCnt == GAP_LAST) & (st_ff.cmdCnt != '0);
    if (ssGoAct | (ssGoIdle & ~tiMode) | gapExpired) begin
      nxt_st.cmdCnt = '0;
    end else if (frameEnd) begin
      nxt_st.cmdCnt = cmdNext;
    end
    // a TI frame train that stops for too long starts a new packet
    if (~tiMode | sclkRise | (st_ff.cmdCnt == '0)) begin
      nxt_st.gapCnt = '0;
    end else if (st_ff.gapCnt != GAP_LAST) begin
      nxt_st.gapCnt = st_ff.gapCnt + CNT_ONE;
    end

    // wishbone access: one wait state, answer registered with ack
    nxt_st.wbAck = wbReq;
    curMasked = {st_ff.raw[STICKY_MSB:STICKY_LSB] & st_ff.cfg[STICKY_MSB:STICKY_LSB],
                 st_ff.raw[SRC_W-1:0] & st_ff.irqEn};
    case (regIdx)
      IDX_MASKED: rdData = DAT_W'(curMasked);
      IDX_RAW:    rdData = DAT_W'(st_ff.raw);
      IDX_CFG:    rdData = DAT_W'(st_ff.cfg);
      IDX_IRQEN:  rdData = DAT_W'({st_ff.irqEn, {EN_LSB{1'b0}}});
      default:    rdData = '0;
    endcase
    nxt_st.wbDat = (wbReq & ~wb_we) ? rdData : '0;
    if (wbWr) begin
      case (regIdx)
        IDX_RAW: begin
          rawClr[STICKY_MSB:STICKY_LSB] = wb_dat_w[STICKY_MSB:STICKY_LSB];
        end
        IDX_CFG: begin
          nxt_st.cfg = wb_dat_w[RAW_W-1:0] & CFG_WMASK;
        end
        IDX_IRQEN: begin
          nxt_st.irqEn = wb_dat_w[EN_MSB:EN_LSB];
        end
        default: begin
          // masked status ignores writes
          nxt_st.raw = st_ff.raw;
        end
      endcase
    end

    // raw status: low four follow the datapath, top two are sticky
    nxt_st.raw[SRC_W-1:0] = {txUnderrunRaw, rxOverflowRaw,
                             rxReadyRaw, txCompleteRaw};
    // set beats a clear arriving in the same cycle
    nxt_st.raw[BIT_SSREL] = (st_ff.raw[BIT_SSREL] & ~rawClr[BIT_SSREL])
                            | ssGoIdle;
    nxt_st.raw[BIT_CMD]   = (st_ff.raw[BIT_CMD] & ~rawClr[BIT_CMD])
                            | cmdHit;

    // transfer frame counter; any config write restarts it
    frmNext = st_ff.frmCnt + CNT_ONE;
    if (nxt_st.cfg[CFG_FCDIS] | clrFrameCount | cfgWrite) begin
      nxt_st.frmCnt = '0;
      nxt_st.pause  = 1'b0;
    end else if (frameEnd & ~st_ff.pause) begin
      nxt_st.frmCnt = frmNext;
      if ((frameCountLimit != '0) & (frmNext == frameCountLimit)) begin
        nxt_st.pause = 1'b1;
      end
    end

    // first-frame handling: discard qualified with the frame-done pulse, status select held through the first frame
    nxt_st.frameDone   = frameEnd;
    nxt_st.rxDiscard   = frameEnd & st_ff.firstFrame & st_ff.cfg[CFG_DISC];
    nxt_st.txStatusSel = st_ff.cfg[CFG_STAT] & slaveMode & nxt_st.firstFrame;

    nxtMasked  = {nxt_st.raw[STICKY_MSB:STICKY_LSB] & nxt_st.cfg[STICKY_MSB:STICKY_LSB],
                  nxt_st.raw[SRC_W-1:0] & nxt_st.irqEn};
    nxt_st.irq = |nxtMasked;
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= SIS_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_r     = st_ff.wbDat;
  assign wb_ack       = st_ff.wbAck;
  assign irqOut       = st_ff.irq;
  assign xferPause    = st_ff.pause;
  assign drainToEmpty = st_ff.cfg[CFG_FCDIS];
  assign frameDone    = st_ff.frameDone;
  assign rxDiscard    = st_ff.rxDiscard;
  assign txStatusSel  = st_ff.txStatusSel;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  mis_readonly_a: assert property (
    wbWr && (regIdx == IDX_MASKED)
    |=> $stable(st_ff.cfg) && $stable(st_ff.irqEn) && $stable(st_ff.raw[STICKY_MSB:STICKY_LSB])
      || $past(ssGoIdle) || $past(cmdHit))
    else $error("write to masked status changed state");

  mis_readback_a: assert property (
    wbReq && !wb_we && (regIdx == IDX_MASKED)
    |=> wb_ack && (wb_dat_r[SRC_W-1:0] == ($past(st_ff.raw[SRC_W-1:0]) & $past(st_ff.irqEn))))
    else $error("masked status readback wrong");

  underrun_mask_a: assert property (
    st_ff.raw[3] && st_ff.irqEn[3] |-> irqOut)
    else $error("under-run not reported");

  overflow_mask_a: assert property (
    st_ff.raw[2] && st_ff.irqEn[2] |-> irqOut)
    else $error("overflow not reported");

  rxready_mask_a: assert property (
    st_ff.raw[1] && st_ff.irqEn[1] |-> irqOut)
    else $error("rx ready not reported");

  tx_complete_raw_mask_a: assert property (
    st_ff.raw[0] && st_ff.irqEn[0] |-> irqOut)
    else $error("tx complete not reported");

  sticky_mask_a: assert property (
    st_ff.raw[BIT_SSREL] && st_ff.cfg[BIT_SSREL] |-> irqOut)
    else $error("select release not reported");

  release_set_a: assert property (
    ssGoIdle |=> st_ff.raw[BIT_SSREL] ##1 st_ff.raw[BIT_SSREL] || $past(rawClr[BIT_SSREL]))
    else $error("select release flag not set");

  cmd_count_a: assert property (
    frameEnd && (commandFrameCount != '0) && (st_ff.cmdCnt + CNT_ONE == commandFrameCount)
    |=> st_ff.raw[BIT_CMD])
    else $error("command count flag not set");

  raw_follow_a: assert property (
    ##1 st_ff.raw[SRC_W-1:0] == $past({txUnderrunRaw, rxOverflowRaw, rxReadyRaw, txCompleteRaw}))
    else $error("raw status does not follow sources");

  limit_pause_a: assert property (
    !nxt_st.cfg[CFG_FCDIS] && !clrFrameCount && !cfgWrite && frameEnd && !st_ff.pause
    && (frameCountLimit != '0) && (st_ff.frmCnt + CNT_ONE == frameCountLimit)
    |=> xferPause)
    else $error("frame limit did not pause");

  fcdis_idle_a: assert property (
    st_ff.cfg[CFG_FCDIS] |-> !xferPause && (st_ff.frmCnt == '0) && drainToEmpty)
    else $error("disabled frame counter active");

  first_discard_a: assert property (
    frameEnd && st_ff.firstFrame && st_ff.cfg[CFG_DISC] |=> frameDone && rxDiscard)
    else $error("first frame not discarded");

  status_first_a: assert property (
    ssGoAct && st_ff.cfg[CFG_STAT] && slaveMode |=> txStatusSel)
    else $error("status frame not selected");

  cmd_restart_a: assert property (
    ssGoIdle && !tiMode |=> st_ff.cmdCnt == '0)
    else $error("command counter not restarted");

  irq_or_a: assert property (
    irqOut == |curMasked)
    else $error("interrupt is not OR of masked bits");

  sticky_hold_a: assert property (
    st_ff.raw[BIT_CMD] && !rawClr[BIT_CMD] |=> st_ff.raw[BIT_CMD])
    else $error("command flag lost without clear");

  // ------------------------------------------------------------------
  // sticky flags, counters, first-frame outputs and bus answer
  // ------------------------------------------------------------------
  cmd_mask_a: assert property (
    st_ff.raw[BIT_CMD] && st_ff.cfg[BIT_CMD] |-> irqOut)
    else $error("command count not reported");

  release_hold_a: assert property (
    st_ff.raw[BIT_SSREL] && !rawClr[BIT_SSREL] |=> st_ff.raw[BIT_SSREL])
    else $error("release flag lost without clear");

  cmd_clear_a: assert property (
    rawClr[BIT_CMD] && !cmdHit |=> !st_ff.raw[BIT_CMD])
    else $error("command flag not cleared");

  pause_hold_a: assert property (
    xferPause && !nxt_st.cfg[CFG_FCDIS] && !clrFrameCount && !cfgWrite |=> xferPause)
    else $error("pause dropped without clear");

  pause_count_a: assert property (
    xferPause && !nxt_st.cfg[CFG_FCDIS] && !clrFrameCount && !cfgWrite
    |=> $stable(st_ff.frmCnt))
    else $error("frame counted while paused");

  discard_pair_a: assert property (
    rxDiscard |-> frameDone)
    else $error("discard outside a frame end");

  status_end_a: assert property (
    frameEnd && !ssGoAct |=> !txStatusSel)
    else $error("status kept past first frame");

  // ti trains skip the select-release restart, so the idle gap and select going active restart them
  gap_restart_a: assert property (
    gapExpired |=> st_ff.cmdCnt == '0)
    else $error("command counter kept after gap");

  act_restart_a: assert property (
    ssGoAct |=> (st_ff.cmdCnt == '0) && st_ff.firstFrame)
    else $error("select start did not restart");

  mis_upper_a: assert property (
    wbReq && !wb_we && (regIdx == IDX_MASKED) |=> wb_dat_r[DAT_W-1:RAW_W] == '0)
    else $error("masked status upper bits not zero");

  ack_pulse_a: assert property (
    wb_ack |=> !wb_ack)
    else $error("ack longer than one cycle");

  rdata_idle_a: assert property (
    !wb_ack |-> wb_dat_r == '0)
    else $error("read data outside ack");

  frame_seen_c: cover property (frameEnd ##[1:200] frameEnd);
  ti_gap_c: cover property (gapExpired);
  release_irq_c: cover property (ssGoIdle ##2 irqOut);
  pause_hit_c: cover property (!xferPause ##1 xferPause);
  clear_race_c: cover property (ssGoIdle && rawClr[BIT_SSREL]);

endmodule

// >>> logic/sis_pkg.sv
package sis_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int ADR_W  = 4;
  localparam int ADR_LSB = 2;
  localparam int DAT_W  = 32;
  localparam int IDX_W  = ADR_W - ADR_LSB;

  // word index of each register (byte address = 4 * index)
  localparam logic [IDX_W-1:0] IDX_MASKED = 2'h0;
  localparam logic [IDX_W-1:0] IDX_RAW    = 2'h1;
  localparam logic [IDX_W-1:0] IDX_CFG    = 2'h2;
  localparam logic [IDX_W-1:0] IDX_IRQEN  = 2'h3;

  // ------------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------------
  localparam int RAW_W      = 6;
  localparam int SRC_W      = 4;
  localparam int BIT_SSREL  = 5;
  localparam int BIT_CMD    = 4;
  localparam int CFG_FCDIS  = 2;
  localparam int CFG_DISC   = 1;
  localparam int CFG_STAT   = 0;
  localparam int EN_LSB     = 4;
  localparam int EN_MSB     = 7;
  localparam int STICKY_LSB = 4;
  localparam int STICKY_MSB = 5;
  localparam logic [RAW_W-1:0] CFG_WMASK = 6'h37;

  // ------------------------------------------------------------------
  // counters and synchronisers
  // ------------------------------------------------------------------
  localparam int CNT_W  = 8;
  localparam int SYNC_N = 3;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef struct packed {
    logic [SYNC_N-1:0] sclkSync;
    logic [SYNC_N-1:0] ssSync;
    logic              sclkLvl;
    logic              ssLvl;
    logic [CNT_W-1:0]  bitCnt;
    logic [CNT_W-1:0]  cmdCnt;
    logic [CNT_W-1:0]  frmCnt;
    logic [CNT_W-1:0]  gapCnt;
    logic              firstFrame;
    logic [RAW_W-1:0]  raw;
    logic [SRC_W-1:0]  irqEn;
    logic [RAW_W-1:0]  cfg;
    logic              wbAck;
    logic [DAT_W-1:0]  wbDat;
    logic              irq;
    logic              pause;
    logic              rxDiscard;
    logic              txStatusSel;
    logic              frameDone;
  } sis_state_type;

  // slave select idles high in the default polarity
  localparam sis_state_type SIS_STATE_RST = '{ssSync: 3'h7, ssLvl: 1'b1, default: '0};

endpackage

// >>> tb/sis_irq_frame_ctrl_tb.sv
`timescale 1ns/1ps

module sis_irq_frame_ctrl_tb
  import sis_pkg::*;
;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             wb_cyc = 1'b0;
  logic             wb_stb = 1'b0;
  logic             wb_we = 1'b0;
  logic [ADR_W-1:0] wb_adr = '0;
  logic [3:0]       wb_sel = 4'hF;
  logic [DAT_W-1:0] wb_dat_w = '0;
  logic [DAT_W-1:0] wb_dat_r;
  logic             wb_ack;
  logic             sclkPin, ssLine, busy;
  logic [3:0]       srcIn = 4'h0;
  logic [CNT_W-1:0] cmdCount = '0;
  logic [CNT_W-1:0] frmLimit = '0;
  logic             slaveMode = 1'b0;
  logic             clrCount = 1'b0;
  logic             tiMode = 1'b0;
  logic             gapOn = 1'b0;
  logic             go = 1'b0;
  logic [3:0]       nFr = 4'h0;
  logic             irqOut, xferPause, drainToEmpty, frameDone, rxDiscard, txStatusSel;
  int               nErrors = 0;
  int               checksDone = 0;
  int               cntDone = 0;
  int               cntDisc = 0;
  int               cntStat = 0;
  logic [DAT_W-1:0] q;

  always #2 core_clk = ~core_clk;

  sis_irq_frame_ctrl dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
    .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .sclkPin(sclkPin),
    .slaveSelectLine0(ssLine), .txUnderrunRaw(srcIn[3]), .rxOverflowRaw(srcIn[2]),
    .rxReadyRaw(srcIn[1]), .txCompleteRaw(srcIn[0]), .commandFrameCount(cmdCount),
    .frameCountLimit(frmLimit), .slaveMode(slaveMode), .tiMode(tiMode),
    .clrFrameCount(clrCount), .irqOut(irqOut), .xferPause(xferPause),
    .drainToEmpty(drainToEmpty), .frameDone(frameDone), .rxDiscard(rxDiscard),
    .txStatusSel(txStatusSel));

  sis_link_model link_u (.go(go), .nFrames(nFr), .ti(tiMode), .gap(gapOn), .sclkPin(sclkPin),
    .ssLine(ssLine), .busy(busy));

  always @(posedge core_clk) begin
    cntDone += int'(frameDone === 1'b1);
    cntDisc += int'(rxDiscard === 1'b1);
    cntStat += int'(txStatusSel === 1'b1);
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic printVerdict();
    if (nErrors == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checksDone++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      nErrors++;
    end
  endtask

  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    q = wb_dat_r;
    if (n >= 50) nErrors++;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic chkIrq(input logic e);
    repeat (2) @(posedge core_clk);
    chk("irqOut", 32'(e), 32'(irqOut));
  endtask

  task automatic runLink(input logic [3:0] n);
    int k;
    k = 0;
    nFr <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    while (busy === 1'b1 && k < 2000) begin
      @(posedge core_clk);
      k++;
    end
    chk("link busy", 32'h0, 32'(busy));
    repeat (8) @(posedge core_clk);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic resetValues();
    rd(4'h0, 32'h0, "masked");
    rd(4'h4, 32'h0, "raw");
    rd(4'h8, 32'h0, "config");
    chk("irqOut", 32'h0, 32'(irqOut));
  endtask

  task automatic maskGating();
    logic [3:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 4'(1 << i);
      srcIn <= s;
      wb(4'hC, 1'b1, 32'({~s, 4'h0}));
      rd(4'h4, 32'(s), "raw live");
      rd(4'h0, 32'h0, "masked off");
      chkIrq(1'b0);
      wb(4'hC, 1'b1, 32'({s, 4'h0}));
      rd(4'h0, 32'(s), "masked on");
      chkIrq(1'b1);
    end
    srcIn <= 4'hF;
    wb(4'hC, 1'b1, 32'hF0);
    wb(4'h0, 1'b1, 32'h0);
    wb(4'h4, 1'b1, 32'h0);
    rd(4'h0, 32'hF, "masked write");
    rd(4'h4, 32'hF, "raw write");
    srcIn <= 4'h0;
    chkIrq(1'b0);
  endtask

  task automatic cmdAndRelease();
    slaveMode <= 1'b1;
    cmdCount <= 8'h02;
    wb(4'h8, 1'b1, 32'h3F);
    rd(4'h8, 32'h37, "config rw");
    chk("drain", 32'h1, 32'(drainToEmpty));
    wb(4'h8, 1'b1, 32'h33);
    chk("drain", 32'h0, 32'(drainToEmpty));
    cntDone = 0;
    cntDisc = 0;
    cntStat = 0;
    runLink(4'h2);
    chk("frames", 32'h2, 32'(cntDone));
    chk("discard", 32'h1, 32'(cntDisc));
    chk("status", 32'h1, 32'(cntStat > 0));
    rd(4'h4, 32'h30, "raw link");
    rd(4'h0, 32'h30, "masked link");
    chkIrq(1'b1);
    wb(4'h8, 1'b1, 32'h03);
    rd(4'h0, 32'h0, "masked gated");
    rd(4'h4, 32'h30, "raw sticky");
    wb(4'h4, 1'b1, 32'h30);
    rd(4'h4, 32'h0, "raw cleared");
    wb(4'h8, 1'b1, 32'h30);
    runLink(4'h1);
    runLink(4'h1);
    rd(4'h4, 32'h20, "cmd restart");
    wb(4'h4, 1'b1, 32'h30);
    chkIrq(1'b0);
  endtask

  task automatic frameLimit();
    cmdCount <= 8'h00;
    frmLimit <= 8'h02;
    wb(4'h8, 1'b1, 32'h0);
    runLink(4'h3);
    chk("pause", 32'h1, 32'(xferPause));
    clrCount <= 1'b1;
    @(posedge core_clk);
    clrCount <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("pause clr", 32'h0, 32'(xferPause));
    frmLimit <= 8'h00;
    wb(4'h8, 1'b1, 32'h04);
    runLink(4'h3);
    chk("no pause", 32'h0, 32'(xferPause));
    chk("drain", 32'h1, 32'(drainToEmpty));
  endtask

  task automatic tiTrain();
    cmdCount <= 8'h02;
    tiMode <= 1'b1;
    gapOn <= 1'b1;
    wb(4'h4, 1'b1, 32'h30);
    runLink(4'h2);
    rd(4'h4, 32'h20, "ti gap restart");
    wb(4'h4, 1'b1, 32'h30);
    gapOn <= 1'b0;
    runLink(4'h2);
    rd(4'h4, 32'h30, "ti train count");
  endtask

  initial begin
    #200000;
    nErrors++;
    printVerdict();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    resetValues();
    maskGating();
    cmdAndRelease();
    frameLimit();
    tiTrain();
    printVerdict();
  end
endmodule

// >>> tb/sis_link_model.sv
`timescale 1ns/1ps

// far-end master: drives select and a 48 ns serial clock only inside frames
module sis_link_model #(
  parameter int BITS = 8
) (
  // control from the bench
  input  wire logic       go,
  input  wire logic [3:0] nFrames,
  input  wire logic       ti,
  input  wire logic       gap,
  // link pins
  output logic            sclkPin,
  output logic            ssLine,
  output logic            busy
);
  initial begin
    sclkPin = 1'b0;
    ssLine = 1'b1;
    busy = 1'b0;
  end

  // odd ns offsets keep serial clock edges away from core clock edges; select edges land on them
  always @(posedge go) begin
    busy = 1'b1;
    ssLine = ti;
    #101;
    repeat (nFrames) begin
      repeat (BITS) begin
        #24 sclkPin = 1'b1;
        #24 sclkPin = 1'b0;
      end
      // a long pause between frames breaks a ti frame train
      if (gap) #200;
    end
    #99;
    ssLine = !ti;
    busy = 1'b0;
  end
endmodule
